// ==== design/bus_cycle_strobe_logic.sv ====
`timescale 1ns/10ps
`include "bus_strobe_defines.svh"

module bus_cycle_strobe_logic #(
  parameter bit EIGHT_BIT = 1'b0
) (
  input logic clk,
  input logic rst_n,
  input logic cycleStart,
  input bus_strobe_pkg::busReq_s cycleReq,
  input logic holdRequest,
  input logic synchronousReady,
  input logic asynchronousReady,
  input logic generalIo6Select,
  input logic floatTestRequest0,
  input logic floatTestRequest1,
  input logic umsCfgLoad,
  input bus_strobe_pkg::umsCfg_s umsCfgIn,
  output logic busFree,
  output logic cycleDone,
  output logic holdAck,
  output logic syncReadyInternal,
  output logic floatTestMode,
  output logic floatTestRequest1PullupEn,
  output bus_strobe_pkg::pinDrive_s dmaCycleStatus,
  output bus_strobe_pkg::pinDrive_s upperZeroIndicator,
  output bus_strobe_pkg::pinDrive_s highByteWriteEnable_n,
  output logic highByteWriteEnablePullupEn,
  output bus_strobe_pkg::pinDrive_s lowByteWriteEnable_n,
  output bus_strobe_pkg::pinDrive_s singleByteWriteEnable_n,
  output bus_strobe_pkg::pinDrive_s writeStrobe_n,
  output bus_strobe_pkg::pinDrive_s upperMemorySelect_n
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  bus_strobe_pkg::phase_e phase;
  bus_strobe_pkg::phase_e nxtPhase;
  bus_strobe_pkg::busReq_s req_ff;
  bus_strobe_pkg::busReq_s nxt_req;
  bus_strobe_pkg::umsCfg_s umsCfg_ff;
  logic busFree_ff;
  logic cycleDone_ff;
  logic holdAck_ff;
  logic nxt_holdAck;
  logic syncReadyInt_ff;
  logic inReset_ff;
  logic sampleDone_ff;
  logic floatTestMode_ff;
  logic syncReadyGated;
  logic readyInt;
  logic accept;
  logic nxtIdle;
  logic canStartNext;
  logic driveOn;
  logic splitLaneOn;
  logic singleLaneOn;
  logic floatFree;
  logic inT1;
  logic inT2to4;
  logic inT1to3;
  logic inT2to3;
  logic inCycle;
  logic upperZero;
  logic nxtWrite_n;
  logic umsHit;
  bus_strobe_pkg::pinDrive_s dmaCycleStatus_ff;
  bus_strobe_pkg::pinDrive_s upperZeroIndicator_ff;
  bus_strobe_pkg::pinDrive_s highByteWe_ff;
  bus_strobe_pkg::pinDrive_s lowByteWe_ff;
  bus_strobe_pkg::pinDrive_s singleByteWe_ff;
  bus_strobe_pkg::pinDrive_s writeStrobe_ff;
  bus_strobe_pkg::pinDrive_s upperMemSel_ff;
  logic highBytePullup_ff;
  logic floatReq1Pullup_ff;

  ////////////////////////////////////////////////////////////////////////////
  // ready path

  // the pin is already aligned to the output clock, so no extra
  // half-cycle synchroniser is inserted; that buys relaxed setup
  // async ready is taken as already synchronised upstream
  always_comb begin
    syncReadyGated = synchronousReady & ~generalIo6Select;
    readyInt = syncReadyGated | asynchronousReady;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncReadyInt_ff <= 1'b0;
    end else begin
      syncReadyInt_ff <= syncReadyGated;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus period sequencer

  bus_phase_seq u_phase_seq (
    .clk(clk),
    .rst_n(rst_n),
    .start(accept),
    .ready(readyInt),
    .phase(phase),
    .nxtPhase(nxtPhase)
  );

  // a pending hold takes priority over a new bus cycle
  always_comb begin
    canStartNext = (phase == bus_strobe_pkg::PH_IDLE) ||
                   (phase == bus_strobe_pkg::PH_T4 && readyInt) ||
                   (phase == bus_strobe_pkg::PH_T4);
    accept = cycleStart & busFree_ff & ~holdRequest & canStartNext;
    nxt_req = accept ? cycleReq : req_ff;
    nxtIdle = nxtPhase == bus_strobe_pkg::PH_IDLE;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ff <= '0;
    end else if (accept) begin
      req_ff <= cycleReq;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busFree_ff <= 1'b0;
    end else begin
      busFree_ff <= ((nxtPhase == bus_strobe_pkg::PH_IDLE) ||
                     (nxtPhase == bus_strobe_pkg::PH_T4)) &
                    ~nxt_holdAck & ~holdRequest & ~inReset_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cycleDone_ff <= 1'b0;
    end else begin
      cycleDone_ff <= nxtPhase == bus_strobe_pkg::PH_T4;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus hold

  // grant only float_test_mode the bus has gone idle, release when request drops
  // a cycle in flight always finishes before the bus is handed over
  always_comb begin
    nxt_holdAck = holdRequest & (holdAck_ff | nxtIdle);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      holdAck_ff <= 1'b0;
    end else begin
      holdAck_ff <= nxt_holdAck;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release and float-test sampling

  // the requests double as outputs later, so they are caught float_test_mode,
  // on the first edge after reset lets go
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inReset_ff <= 1'b1;
      sampleDone_ff <= 1'b0;
    end else begin
      inReset_ff <= 1'b0;
      sampleDone_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      floatTestMode_ff <= 1'b0;
    end else if (!sampleDone_ff) begin
      floatTestMode_ff <= ~floatTestRequest0 & ~floatTestRequest1;
    end
  end

  // pull-ups exist only while reset holds; they must not load the pins
  // float_test_mode the strobes are driven
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      floatReq1Pullup_ff <= 1'b1;
      highBytePullup_ff <= 1'b1;
    end else begin
      floatReq1Pullup_ff <= 1'b0;
      highBytePullup_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // upper memory block configuration

  // no software port here; the owner of the chip-select setup loads it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      umsCfg_ff.base <= `UMS_DEFAULT_BASE;
      umsCfg_ff.size <= `UMS_DEFAULT_SIZE;
    end else if (umsCfgLoad) begin
      // a load reaches the decode for cycles accepted after that edge
      umsCfg_ff <= umsCfgIn;
    end
  end

  upper_block_decode u_upper_decode (
    .addr(nxt_req.addr),
    .cfg(umsCfg_ff),
    .hit(umsHit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // period decode and drive gating

  // pins follow nxtPhase so each registered output lines up with phase
  always_comb begin
    inT1 = nxtPhase == bus_strobe_pkg::PH_T1;
    inT2to3 = (nxtPhase == bus_strobe_pkg::PH_T2) ||
              (nxtPhase == bus_strobe_pkg::PH_T3);
    inT2to4 = inT2to3 || (nxtPhase == bus_strobe_pkg::PH_T4);
    inT1to3 = inT1 || inT2to3;
    inCycle = inT1 || inT2to4;
    floatFree = sampleDone_ff & ~floatTestMode_ff;
    driveOn = floatFree & ~nxt_holdAck;
    // variant is fixed per build; the enables it leaves unused stay floated
    splitLaneOn = driveOn & ~EIGHT_BIT;
    singleLaneOn = driveOn & EIGHT_BIT;
    upperZero = ~|nxt_req.addr[`UPPER_ZERO_ADDR_HI:`UPPER_ZERO_ADDR_LO];
    nxtWrite_n = ~(inT2to3 & nxt_req.write);
  end

  ////////////////////////////////////////////////////////////////////////////
  // dma cycle status

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dmaCycleStatus_ff <= '0;
    end else begin
      // low through the first period so the status never leads the cycle
      dmaCycleStatus_ff.level <= inT2to4 & nxt_req.dma;
      dmaCycleStatus_ff.oe <= driveOn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // upper zero indicator

  // only valid in the first period; not a cycle-long qualifier
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upperZeroIndicator_ff <= '0;
    end else begin
      upperZeroIndicator_ff.level <= inT1 & upperZero;
      upperZeroIndicator_ff.oe <= driveOn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write strobe

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      writeStrobe_ff <= '0;
    end else begin
      // low in the second and third periods, wait states included
      writeStrobe_ff.level <= nxtWrite_n;
      writeStrobe_ff.oe <= driveOn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte write enables

  // the sixteen-bit variant uses the split enables, the eight-bit one the
  // single early enable; the unused pins stay floated
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      highByteWe_ff <= '0;
    end else begin
      highByteWe_ff.level <= nxt_req.byteHighEn_n | nxtWrite_n;
      highByteWe_ff.oe <= splitLaneOn;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowByteWe_ff <= '0;
    end else begin
      lowByteWe_ff.level <= nxt_req.addr[0] | nxtWrite_n;
      lowByteWe_ff.oe <= splitLaneOn;
    end
  end

  // early timing: opens with the address in the first period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      singleByteWe_ff <= '0;
    end else begin
      singleByteWe_ff.level <= ~(inT1to3 & nxt_req.write);
      singleByteWe_ff.oe <= singleLaneOn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // upper memory select

  // during hold this pin keeps driving high so memory stays deselected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upperMemSel_ff <= '0;
    end else begin
      upperMemSel_ff.level <= nxt_holdAck |
                              ~(inCycle & nxt_req.memory & umsHit);
      upperMemSel_ff.oe <= floatFree;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign busFree = busFree_ff;
  assign cycleDone = cycleDone_ff;
  assign holdAck = holdAck_ff;
  assign syncReadyInternal = syncReadyInt_ff;
  assign floatTestMode = floatTestMode_ff;
  assign floatTestRequest1PullupEn = floatReq1Pullup_ff;
  assign dmaCycleStatus = dmaCycleStatus_ff;
  assign upperZeroIndicator = upperZeroIndicator_ff;
  assign highByteWriteEnable_n = highByteWe_ff;
  assign highByteWriteEnablePullupEn = highBytePullup_ff;
  assign lowByteWriteEnable_n = lowByteWe_ff;
  assign singleByteWriteEnable_n = singleByteWe_ff;
  assign writeStrobe_n = writeStrobe_ff;
  assign upperMemorySelect_n = upperMemSel_ff;

endmodule

// ==== design/bus_phase_seq.sv ====
`timescale 1ns/10ps
`include "bus_strobe_defines.svh"

module bus_phase_seq (
  input logic clk,
  input logic rst_n,
  input logic start,
  input logic ready,
  output bus_strobe_pkg::phase_e phase,
  output bus_strobe_pkg::phase_e nxtPhase
);

  bus_strobe_pkg::phase_e phase_ff;

  // wait states repeat the third period until ready is seen
  always_comb begin
    nxtPhase = phase_ff;
    case (phase_ff)
      bus_strobe_pkg::PH_IDLE: begin
        nxtPhase = start ? bus_strobe_pkg::PH_T1 : bus_strobe_pkg::PH_IDLE;
      end
      bus_strobe_pkg::PH_T1: begin
        nxtPhase = bus_strobe_pkg::PH_T2;
      end
      bus_strobe_pkg::PH_T2: begin
        nxtPhase = bus_strobe_pkg::PH_T3;
      end
      bus_strobe_pkg::PH_T3: begin
        nxtPhase = ready ? bus_strobe_pkg::PH_T4 : bus_strobe_pkg::PH_T3;
      end
      bus_strobe_pkg::PH_T4: begin
        nxtPhase = start ? bus_strobe_pkg::PH_T1 : bus_strobe_pkg::PH_IDLE;
      end
      default: begin
        nxtPhase = bus_strobe_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= bus_strobe_pkg::PH_IDLE;
    end else begin
      phase_ff <= nxtPhase;
    end
  end

  assign phase = phase_ff;

endmodule

// ==== design/bus_strobe_defines.svh ====
// Function
// - dma cycle status driven high in periods two to four of dma cycles
// - dma cycle status floats during bus hold and reset
// - upper zero indicator true only when address bits 19 to 16 are zero
// - upper zero indicator asserted in first period, dropped in second
// - upper zero indicator floats during bus hold and float-test mode
// - high byte write enable is byte high enable ORed with write strobe
// - high byte write enable pulled up in reset, floats in hold or float-test
// - low byte write enable is address bit zero ORed with write strobe
// - eight-bit variant asserts single byte write enable early on every write
// - write strobe asserted for writes, floats during bus hold and reset
// - upper memory select for programmable block up to 512k, high in hold
// - upper memory select defaults to 64k block f0000 to fffff
// - both float-test requests sampled at reset release, both low enters mode
// - float-test mode floats every pin until the next reset
// - weak pull-up on second float-test request only while reset is active
// - synchronous ready is an active-high level sampled without extra sync
// - synchronous ready forced low internally when pin used as general io
`ifndef BUS_STROBE_DEFINES_SVH
`define BUS_STROBE_DEFINES_SVH

`define ADDR_W 20
`define UPPER_ZERO_ADDR_HI 19
`define UPPER_ZERO_ADDR_LO 16
`define UMS_SIZE_W 2
`define UMS_DEFAULT_BASE 20'hf0000
`define UMS_DEFAULT_SIZE 2'h0
`define UMS_KEEP_MASK_64K 20'hf0000

`endif

// ==== design/bus_strobe_pkg.sv ====
`include "bus_strobe_defines.svh"

package bus_strobe_pkg;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_T1,
    PH_T2,
    PH_T3,
    PH_T4
  } phase_e;

  typedef struct packed {
    logic dma;
    logic write;
    logic memory;
    logic byteHighEn_n;
    logic [`ADDR_W-1:0] addr;
  } busReq_s;

  typedef struct packed {
    logic [`ADDR_W-1:0] base;
    logic [`UMS_SIZE_W-1:0] size;
  } umsCfg_s;

  typedef struct packed {
    logic level;
    logic oe;
  } pinDrive_s;

endpackage

// ==== design/upper_block_decode.sv ====
`timescale 1ns/10ps
`include "bus_strobe_defines.svh"

module upper_block_decode (
  input logic [`ADDR_W-1:0] addr,
  input bus_strobe_pkg::umsCfg_s cfg,
  output logic hit
);

  logic [`ADDR_W-1:0] keepMask;

  // block size is 64k shifted by the size code, so 512k at most
  always_comb begin
    keepMask = `UMS_KEEP_MASK_64K << cfg.size;
    hit = ((addr ^ cfg.base) & keepMask) == '0;
  end

endmodule

// ==== dv/bus_cycle_strobe_logic_assertions.sv ====
`timescale 1ns/10ps
module bus_cycle_strobe_logic_assertions (
  input logic clk,
  input logic rst_n,
  input logic cycleStart,
  input logic holdRequest,
  input logic generalIo6Select,
  input logic busFree,
  input logic cycleDone,
  input logic holdAck,
  input logic syncReadyInternal,
  input logic floatTestMode,
  input logic floatTestRequest1PullupEn,
  input logic highByteWriteEnablePullupEn,
  input bus_strobe_pkg::pinDrive_s dmaCycleStatus,
  input bus_strobe_pkg::pinDrive_s upperZeroIndicator,
  input bus_strobe_pkg::pinDrive_s highByteWriteEnable_n,
  input bus_strobe_pkg::pinDrive_s lowByteWriteEnable_n,
  input bus_strobe_pkg::pinDrive_s writeStrobe_n,
  input bus_strobe_pkg::pinDrive_s upperMemorySelect_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  chk_hold_floats: assert property (
    holdAck |-> !writeStrobe_n.oe && !dmaCycleStatus.oe && !upperZeroIndicator.oe)
    else $error("pins driven during hold");
  chk_hold_ums_high: assert property (
    holdAck && !floatTestMode |-> upperMemorySelect_n.level && upperMemorySelect_n.oe)
    else $error("upper select not high in hold");
  chk_float_floats: assert property (
    floatTestMode |-> !writeStrobe_n.oe && !upperMemorySelect_n.oe
      && !highByteWriteEnable_n.oe && !lowByteWriteEnable_n.oe)
    else $error("pin driven in float mode");
  chk_float_sticky: assert property (
    floatTestMode |=> floatTestMode)
    else $error("float mode left without reset");
  chk_hb_or: assert property (
    highByteWriteEnable_n.oe && !highByteWriteEnable_n.level |-> !writeStrobe_n.level)
    else $error("high byte enable without strobe");
  chk_lb_or: assert property (
    lowByteWriteEnable_n.oe && !lowByteWriteEnable_n.level |-> !writeStrobe_n.level)
    else $error("low byte enable without strobe");
  chk_upper_zero_pulse: assert property (
    upperZeroIndicator.oe && upperZeroIndicator.level |=> !upperZeroIndicator.level)
    else $error("upper zero held past first period");
  chk_pullup_drop: assert property (
    floatTestRequest1PullupEn |=> !floatTestRequest1PullupEn && !highByteWriteEnablePullupEn)
    else $error("pull-up kept after reset");
  chk_ready_forced_low: assert property (
    generalIo6Select |=> !syncReadyInternal)
    else $error("ready not forced low");
  // four periods at least, then up to 40 periods for ready, far beyond the slowest ready the bench commands
  chk_cycle_len: assert property (
    cycleStart && busFree && !holdRequest |-> ##1 !cycleDone [*3] ##[1:40] cycleDone)
    else $error("cycle length wrong");
  ////////////////////////////////////////////////////////////////
  cover property (cycleDone);
  cover property (holdAck);
  cover property (floatTestMode);
  cover property (dmaCycleStatus.oe && dmaCycleStatus.level);
endmodule

bind bus_cycle_strobe_logic bus_cycle_strobe_logic_assertions chk_i (.clk(clk),
  .rst_n(rst_n), .cycleStart(cycleStart), .holdRequest(holdRequest),
  .generalIo6Select(generalIo6Select), .busFree(busFree), .cycleDone(cycleDone),
  .holdAck(holdAck), .syncReadyInternal(syncReadyInternal), .floatTestMode(floatTestMode),
  .floatTestRequest1PullupEn(floatTestRequest1PullupEn),
  .highByteWriteEnablePullupEn(highByteWriteEnablePullupEn),
  .dmaCycleStatus(dmaCycleStatus), .upperZeroIndicator(upperZeroIndicator),
  .highByteWriteEnable_n(highByteWriteEnable_n), .lowByteWriteEnable_n(lowByteWriteEnable_n),
  .writeStrobe_n(writeStrobe_n), .upperMemorySelect_n(upperMemorySelect_n));

// ==== dv/ext_mem_model.sv ====
`timescale 1ns/10ps
module ext_mem_model (
  input logic clk,
  input logic rst_n,
  input logic busFree,
  input logic [1:0] waitN,
  output logic synchronousReady
);
  logic [2:0] cnt_ff;
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 3'h0;
    end else begin
      cnt_ff <= busFree ? 3'h0 : cnt_ff + 3'h1;
    end
  end
  // slow device: ready once the cycle is waitN+2 periods old, held high while idle
  assign synchronousReady = busFree || (cnt_ff >= {1'b0, waitN} + 3'h2);
endmodule

// ==== dv/tb_bus_cycle_strobe_logic.sv ====
`timescale 1ns/10ps
module tb_bus_cycle_strobe_logic;
  logic clk, rst_n, cycleStart, holdRequest, synchronousReady, asynchronousReady;
  logic generalIo6Select, floatTestRequest0, floatTestRequest1, umsCfgLoad;
  logic busFree, cycleDone, holdAck, syncReadyInternal, floatTestMode;
  logic floatTestRequest1PullupEn, highByteWriteEnablePullupEn;
  logic [1:0] waitN;
  bus_strobe_pkg::busReq_s cycleReq;
  bus_strobe_pkg::umsCfg_s umsCfgIn, cfg;
  bus_strobe_pkg::pinDrive_s dmaCycleStatus, upperZeroIndicator, highByteWriteEnable_n;
  bus_strobe_pkg::pinDrive_s lowByteWriteEnable_n, singleByteWriteEnable_n;
  bus_strobe_pkg::pinDrive_s writeStrobe_n, upperMemorySelect_n;
  int n_mismatch, checks_done;
  logic [19:0] corner [7] = '{20'h00000, 20'h0ffff, 20'h10000, 20'hf0000, 20'hfffff,
    20'h7ffff, 20'h80000};

  bus_cycle_strobe_logic dut (.clk(clk), .rst_n(rst_n), .cycleStart(cycleStart),
    .cycleReq(cycleReq), .holdRequest(holdRequest), .synchronousReady(synchronousReady),
    .asynchronousReady(asynchronousReady), .generalIo6Select(generalIo6Select),
    .floatTestRequest0(floatTestRequest0), .floatTestRequest1(floatTestRequest1),
    .umsCfgLoad(umsCfgLoad), .umsCfgIn(umsCfgIn), .busFree(busFree), .cycleDone(cycleDone),
    .holdAck(holdAck), .syncReadyInternal(syncReadyInternal), .floatTestMode(floatTestMode),
    .floatTestRequest1PullupEn(floatTestRequest1PullupEn),
    .highByteWriteEnablePullupEn(highByteWriteEnablePullupEn),
    .dmaCycleStatus(dmaCycleStatus), .upperZeroIndicator(upperZeroIndicator),
    .highByteWriteEnable_n(highByteWriteEnable_n), .lowByteWriteEnable_n(lowByteWriteEnable_n),
    .singleByteWriteEnable_n(singleByteWriteEnable_n), .writeStrobe_n(writeStrobe_n),
    .upperMemorySelect_n(upperMemorySelect_n));
  ext_mem_model mem (.clk(clk), .rst_n(rst_n), .busFree(busFree), .waitN(waitN),
    .synchronousReady(synchronousReady));

  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic waitFor(ref logic s, input logic v);
    for (int i = 0; i < 60 && s !== v; i++) begin
      @(posedge clk);
      #1;
    end
    if (s !== v) begin
      n_mismatch++;
      $display("MISMATCH t=%0t wait ran out", $time);
      print_verdict();
    end
  endtask

  // expected upper select, mirrors the bench copy of the block config
  function automatic logic umsHit(input bus_strobe_pkg::busReq_s r);
    return r.memory && (((r.addr ^ cfg.base) & (20'hf0000 << cfg.size)) == 20'h0);
  endfunction

  task automatic doReset(input logic f0, input logic f1);
    @(posedge clk);
    rst_n <= 1'b0;
    floatTestRequest0 <= f0;
    floatTestRequest1 <= f1;
    cfg = '{base: 20'hf0000, size: 2'h0};
    repeat (15) @(posedge clk);
    #1;
    chk({writeStrobe_n.oe, dmaCycleStatus.oe}, 2'b00);
    chk({floatTestRequest1PullupEn, highByteWriteEnablePullupEn}, 2'b11);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({floatTestRequest1PullupEn, highByteWriteEnablePullupEn}, 2'b00);
    chk({floatTestMode, 1'b0}, {~(f0 | f1), 1'b0});
  endtask

  // called right after a rising edge; holds the request until taken
  task automatic run(input bus_strobe_pkg::busReq_s r);
    cycleReq <= r;
    cycleStart <= 1'b1;
    #1;
    waitFor(busFree, 1'b1);
    @(posedge clk);
    cycleStart <= 1'b0;
    #1;
    chk(upperZeroIndicator, {r.addr[19:16] == 4'h0, 1'b1});
    chk(upperMemorySelect_n, {~umsHit(r), 1'b1});
    chk(dmaCycleStatus, 2'b01);
    chk(singleByteWriteEnable_n, {~r.write, 1'b0});
    @(posedge clk);
    #1;
    chk(upperZeroIndicator, 2'b01);
    chk(dmaCycleStatus, {r.dma, 1'b1});
    chk(writeStrobe_n, {~r.write, 1'b1});
    chk(highByteWriteEnable_n, {r.byteHighEn_n | ~r.write, 1'b1});
    chk(lowByteWriteEnable_n, {r.addr[0] | ~r.write, 1'b1});
    waitFor(cycleDone, 1'b1);
    chk(writeStrobe_n, 2'b11);
    chk(dmaCycleStatus, {r.dma, 1'b1});
    chk(singleByteWriteEnable_n, 2'b10);
  endtask

  task automatic burst(input int n);
    bus_strobe_pkg::busReq_s r;
    for (int k = 0; k < n; k++) begin
      r = 24'($urandom);
      if (k < 7) begin
        r.addr = corner[k];
        r.memory = 1'b1;
      end
      @(posedge clk);
      waitN <= 2'($urandom);
      run(r);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {cycleStart, holdRequest, asynchronousReady, generalIo6Select, umsCfgLoad} = 5'h0;
    {floatTestRequest0, floatTestRequest1} = 2'h3;
    cycleReq = '0;
    umsCfgIn = '0;
    waitN = 2'h0;
    n_mismatch = 0;
    checks_done = 0;
    void'($urandom(32'hff89ac2c));
    // every strap pair; the last leaves the block in normal mode
    for (int j = 0; j < 4; j++) begin
      doReset(j[0], j[1]);
      if (j == 0) begin
        repeat (5) @(posedge clk);
        #1;
        chk({upperZeroIndicator.oe, singleByteWriteEnable_n.oe}, 2'b00);
        chk({writeStrobe_n.oe, upperMemorySelect_n.oe}, 2'b00);
      end
    end
    burst(20);
    @(posedge clk);
    umsCfgIn <= '{base: 20'h80000, size: 2'h3};
    umsCfgLoad <= 1'b1;
    @(posedge clk);
    umsCfgLoad <= 1'b0;
    cfg = '{base: 20'h80000, size: 2'h3};
    burst(20);
    // ready pin as general io: internal ready low, async ready completes
    @(posedge clk);
    generalIo6Select <= 1'b1;
    asynchronousReady <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({syncReadyInternal, 1'b0}, 2'b00);
    @(posedge clk);
    run(24'h0);
    @(posedge clk);
    generalIo6Select <= 1'b0;
    asynchronousReady <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({syncReadyInternal, 1'b0}, 2'b10);
    @(posedge clk);
    holdRequest <= 1'b1;
    #1;
    waitFor(holdAck, 1'b1);
    chk({writeStrobe_n.oe, dmaCycleStatus.oe}, 2'b00);
    chk({highByteWriteEnable_n.oe, lowByteWriteEnable_n.oe}, 2'b00);
    chk(upperMemorySelect_n, 2'b11);
    @(posedge clk);
    holdRequest <= 1'b0;
    #1;
    waitFor(holdAck, 1'b0);
    doReset(1'b1, 1'b1);
    burst(4);
    print_verdict();
  end
endmodule
